// [core/frame_regs_pkg.sv]
// Package with register offsets, field layouts, reset values and timing for the block
package frame_regs_pkg;
  localparam logic [7:0] DONE_HEAD_OFFSET = 8'h30;
  localparam logic [7:0] FRAME_INTERVAL_OFFSET = 8'h34;
  localparam logic [7:0] FRAME_REMAINING_OFFSET = 8'h38;
  localparam int DH_LSB = 4;
  localparam int FI_MSB = 13;
  localparam int FI_WIDTH = 14;
  localparam int BUDGET_LSB = 16;
  localparam int BUDGET_MSB = 30;
  localparam int BUDGET_WIDTH = 15;
  localparam int TOGGLE_BIT = 31;
  localparam logic [31:0] DONE_HEAD_RESET = 32'h0000_0000;
  localparam logic [13:0] FI_NOMINAL = 14'h2edf;
  localparam logic [31:0] FRAME_INTERVAL_RESET = {18'h00000, FI_NOMINAL};
  localparam logic [13:0] FRAME_LEFT_RESET = 14'h0000;
  localparam logic [31:0] DH_FIELD_MASK = 32'hffff_fff0;
  localparam logic [31:0] FI_FIELD_MASK = 32'hffff_3fff;
  // 12 Mbit/s bit time at 125 MHz
  localparam int BIT_TIME_PS = 83333;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BIT_TIME_CYCLES = BIT_TIME_PS / CLK_PERIOD_PS;
  localparam logic [3:0] BIT_TIME_LAST = 4'(BIT_TIME_CYCLES - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [BUDGET_WIDTH-1:0] budget;
    logic sof;
  } frame_out_type;
endpackage : frame_regs_pkg

// [core/frame_timer.sv]
// Frame remaining down counter with toggle copy and start-of-frame strobe
`timescale 1ns/1ps
module frame_timer
  import frame_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [FI_WIDTH-1:0] interval,
  input wire logic interval_toggle,
  output logic [FI_WIDTH-1:0] frame_bits_left,
  output logic remaining_toggle,
  output logic sof
);
  logic [3:0] tick_q;
  logic [FI_WIDTH-1:0] left_q;
  logic rtog_q;
  logic sof_q;
  wire bit_tick = (tick_q == BIT_TIME_LAST);
  wire at_zero = (left_q == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= 4'h0;
    end else begin
      tick_q <= bit_tick ? 4'h0 : tick_q + 4'h1;
    end
  end

  // Zero lasts one bit time, reload happens at the next boundary
  // Count starts at zero, so the first bit time after reset loads the interval
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q <= FRAME_LEFT_RESET;
      rtog_q <= 1'b0;
      sof_q <= 1'b0;
    end else begin
      sof_q <= bit_tick && at_zero;
      if (bit_tick) begin
        left_q <= at_zero ? interval : left_q - 14'h0001;
        if (at_zero) begin
          rtog_q <= interval_toggle;
        end
      end
    end
  end

  assign frame_bits_left = left_q;
  assign remaining_toggle = rtog_q;
  assign sof = sof_q;

  reload_value_a: assert property (@(posedge clk) disable iff (rst)
    bit_tick && at_zero |=> left_q == $past(interval)) else $error("frame reload wrong");
  decrement_step_a: assert property (@(posedge clk) disable iff (rst)
    bit_tick && !at_zero |=> left_q == $past(left_q) - 14'h0001) else $error("no decrement");
  toggle_copy_a: assert property (@(posedge clk) disable iff (rst)
    bit_tick && at_zero |=> rtog_q == $past(interval_toggle)) else $error("toggle not copied");
  hold_between_a: assert property (@(posedge clk) disable iff (rst)
    !bit_tick |=> $stable(left_q)) else $error("count moved off bit time");
  frame_start_c: cover property (@(posedge clk) disable iff (rst) sof_q);
endmodule : frame_timer

// [core/done_frame_regs.sv]
// Done queue head pointer and frame interval registers with frame timing
`timescale 1ns/1ps
module done_frame_regs
  import frame_regs_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic TD_DONE,
  input wire logic [31:0] TD_ADDR,
  output logic LINK_WR,
  output logic [31:0] LINK_ADDR,
  output logic [31:0] LINK_DATA,
  input wire logic HCCA_POST,
  output logic [31:0] HCCA_DONE_HEAD,
  output logic HCCA_WR,
  output logic SOF,
  output logic [BUDGET_WIDTH-1:0] PACKET_BUDGET
);
  reg_req_type req;
  frame_out_type fout;
  logic [31:0] done_head_q;
  logic [31:0] done_head_d;
  logic [31:0] interval_q;
  logic [31:0] interval_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic link_wr_q;
  logic [31:0] link_addr_q;
  logic [31:0] link_data_q;
  logic hcca_wr_q;
  logic [31:0] hcca_data_q;
  logic [BUDGET_WIDTH-1:0] budget_q;
  logic [FI_WIDTH-1:0] bits_left;
  logic rem_toggle;
  logic sof_pulse;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  wire wr_dh = req.wr && hit(req.addr, DONE_HEAD_OFFSET);
  wire wr_fi = req.wr && hit(req.addr, FRAME_INTERVAL_OFFSET);
  wire [31:0] td_addr_aligned = TD_ADDR & DH_FIELD_MASK;

  // Completion wins over posting in one cycle: the posted head goes out on
  // HCCA_DONE_HEAD and the new head links to zero, so no descriptor falls out of the queue
  always_comb begin
    done_head_d = done_head_q;
    if (wr_dh) begin
      done_head_d = req.wdata & DH_FIELD_MASK;
    end
    if (HCCA_POST) begin
      done_head_d = DONE_HEAD_RESET;
    end
    if (TD_DONE) begin
      done_head_d = td_addr_aligned;
    end
  end

  assign interval_d = wr_fi ? (req.wdata & FI_FIELD_MASK) : interval_q;

  wire [31:0] remaining_view = {rem_toggle, 17'h00000, bits_left};
  assign rdata_d = !req.rd ? rdata_q :
                   hit(req.addr, DONE_HEAD_OFFSET) ? done_head_q :
                   hit(req.addr, FRAME_INTERVAL_OFFSET) ? interval_q :
                   hit(req.addr, FRAME_REMAINING_OFFSET) ? remaining_view : 32'h0000_0000;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      done_head_q <= DONE_HEAD_RESET;
      interval_q <= FRAME_INTERVAL_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      done_head_q <= done_head_d;
      interval_q <= interval_d;
      rdata_q <= rdata_d;
    end
  end

  // Link write carries the old head, taken before it is overwritten, or zero when a post comes in the same cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      link_wr_q <= 1'b0;
      link_addr_q <= 32'h0000_0000;
      link_data_q <= 32'h0000_0000;
      hcca_wr_q <= 1'b0;
      hcca_data_q <= 32'h0000_0000;
    end else begin
      link_wr_q <= TD_DONE;
      if (TD_DONE) begin
        link_addr_q <= td_addr_aligned;
        link_data_q <= HCCA_POST ? DONE_HEAD_RESET : done_head_q;
      end
      hcca_wr_q <= HCCA_POST;
      if (HCCA_POST) begin
        hcca_data_q <= done_head_q;
      end
    end
  end

  // Budget is the software value as written, latched once per frame
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      budget_q <= 15'h0000;
    end else if (sof_pulse) begin
      budget_q <= interval_q[BUDGET_MSB:BUDGET_LSB];
    end
  end

  frame_timer timer (
    .clk(MCLK),
    .rst(RST),
    .interval(interval_q[FI_MSB:0]),
    .interval_toggle(interval_q[TOGGLE_BIT]),
    .frame_bits_left(bits_left),
    .remaining_toggle(rem_toggle),
    .sof(sof_pulse)
  );

  assign fout = '{budget: budget_q, sof: sof_pulse};
  assign REG_RDATA = rdata_q;
  assign LINK_WR = link_wr_q;
  assign LINK_ADDR = link_addr_q;
  assign LINK_DATA = link_data_q;
  assign HCCA_WR = hcca_wr_q;
  assign HCCA_DONE_HEAD = hcca_data_q;
  assign SOF = fout.sof;
  assign PACKET_BUDGET = fout.budget;

  head_update_a: assert property (@(posedge MCLK) disable iff (RST)
    TD_DONE |=> done_head_q == $past(td_addr_aligned)) else $error("head not updated");
  link_old_head_a: assert property (@(posedge MCLK) disable iff (RST)
    TD_DONE && !HCCA_POST |=> LINK_WR && LINK_DATA == $past(done_head_q))
    else $error("link data wrong");
  post_clears_a: assert property (@(posedge MCLK) disable iff (RST)
    HCCA_POST && !TD_DONE |=> done_head_q == 32'h0 && HCCA_DONE_HEAD == $past(done_head_q))
    else $error("post did not clear");
  reserved_low_a: assert property (@(posedge MCLK) disable iff (RST)
    done_head_q[3:0] == 4'h0) else $error("reserved bits set");
  interval_write_a: assert property (@(posedge MCLK) disable iff (RST)
    wr_fi |=> interval_q == ($past(req.wdata) & FI_FIELD_MASK)) else $error("write lost");
  budget_load_a: assert property (@(posedge MCLK) disable iff (RST)
    sof_pulse |=> PACKET_BUDGET == $past(interval_q[BUDGET_MSB:BUDGET_LSB]))
    else $error("budget not loaded");
  read_back_a: assert property (@(posedge MCLK) disable iff (RST)
    REG_RD && REG_ADDR == FRAME_INTERVAL_OFFSET |=> REG_RDATA == $past(interval_q))
    else $error("read data wrong");
  reset_nominal_a: assert property (@(posedge MCLK)
    $fell(RST) |-> interval_q == FRAME_INTERVAL_RESET) else $error("bad interval reset");
  completion_c: cover property (@(posedge MCLK) disable iff (RST) TD_DONE ##1 TD_DONE);
  post_c: cover property (@(posedge MCLK) disable iff (RST) TD_DONE ##[1:5] HCCA_POST);
  retune_c: cover property (@(posedge MCLK) disable iff (RST) wr_fi ##[1:20] SOF);
endmodule : done_frame_regs

// [test/tb_top.sv]
// Self-checking bench for the done queue head and frame interval registers
`timescale 1ns/1ps
module tb_top;
  import frame_regs_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0000_0000;
  logic [31:0] REG_RDATA;
  logic TD_DONE = 1'b0;
  logic [31:0] TD_ADDR = 32'h0000_0000;
  logic LINK_WR;
  logic [31:0] LINK_ADDR;
  logic [31:0] LINK_DATA;
  logic HCCA_POST = 1'b0;
  logic [31:0] HCCA_DONE_HEAD;
  logic HCCA_WR;
  logic SOF;
  logic [BUDGET_WIDTH-1:0] PACKET_BUDGET;
  logic [31:0] v1;
  logic [31:0] v2;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  done_frame_regs i_done_frame_regs (.MCLK(MCLK), .RST(RST), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .TD_DONE(TD_DONE), .TD_ADDR(TD_ADDR), .LINK_WR(LINK_WR), .LINK_ADDR(LINK_ADDR),
    .LINK_DATA(LINK_DATA), .HCCA_POST(HCCA_POST), .HCCA_DONE_HEAD(HCCA_DONE_HEAD),
    .HCCA_WR(HCCA_WR), .SOF(SOF), .PACKET_BUDGET(PACKET_BUDGET));

  initial begin
    forever #4 MCLK = ~MCLK;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= addr;
    REG_WDATA <= data;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= addr;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1;
    data = REG_RDATA;
  endtask : reg_read

  task automatic t_reset;
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, DONE_HEAD_RESET, "head reset");
    reg_read(FRAME_INTERVAL_OFFSET, v1);
    check(v1, 32'h0000_2edf, "interval reset");
    reg_read(8'h3c, v1);
    check(v1, 32'h0000_0000, "unmapped read");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_regs;
    reg_write(DONE_HEAD_OFFSET, 32'hffff_fff0);
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, 32'hffff_fff0, "head mask");
    reg_write(FRAME_INTERVAL_OFFSET, 32'hffff_3fff);
    reg_write(8'h3c, 32'h0000_0000);
    reg_read(FRAME_INTERVAL_OFFSET, v1);
    check(v1, 32'hffff_3fff, "interval mask");
    $display("t_regs done");
  endtask : t_regs

  // Back-to-back completions: second link must carry the first address
  task automatic t_done;
    @(posedge MCLK);
    TD_DONE <= 1'b1;
    TD_ADDR <= 32'h0001_0020;
    @(posedge MCLK);
    TD_ADDR <= 32'h0002_0040;
    #1;
    check({LINK_WR, 31'h0}, 32'h8000_0000, "link strobe");
    check(LINK_DATA, 32'hffff_fff0, "link old head");
    check(LINK_ADDR, 32'h0001_0020, "link addr");
    @(posedge MCLK);
    TD_DONE <= 1'b0;
    #1;
    check(LINK_DATA, 32'h0001_0020, "chained head");
    check(LINK_ADDR, 32'h0002_0040, "link addr 2");
    @(posedge MCLK);
    #1;
    check({LINK_WR, 31'h0}, 32'h0000_0000, "link strobe end");
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, 32'h0002_0040, "newest head");
    $display("t_done done");
  endtask : t_done

  task automatic t_post;
    @(posedge MCLK);
    HCCA_POST <= 1'b1;
    @(posedge MCLK);
    HCCA_POST <= 1'b0;
    #1;
    check({HCCA_WR, 31'h0}, 32'h8000_0000, "post strobe");
    check(HCCA_DONE_HEAD, 32'h0002_0040, "posted head");
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, 32'h0000_0000, "cleared head");
    @(posedge MCLK);
    TD_DONE <= 1'b1;
    TD_ADDR <= 32'h0003_0067;
    @(posedge MCLK);
    TD_DONE <= 1'b0;
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, 32'h0003_0060, "low bits dropped");
    @(posedge MCLK);
    TD_DONE <= 1'b1;
    TD_ADDR <= 32'h0004_0080;
    HCCA_POST <= 1'b1;
    @(posedge MCLK);
    TD_DONE <= 1'b0;
    HCCA_POST <= 1'b0;
    #1;
    check(HCCA_DONE_HEAD, 32'h0003_0060, "posted with completion");
    check(LINK_DATA, 32'h0000_0000, "link after post");
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, 32'h0004_0080, "completion beats post");
    $display("t_post done");
  endtask : t_post

  // 100 cycles is exactly ten bit times, far from any reload
  task automatic t_timer;
    reg_read(FRAME_REMAINING_OFFSET, v1);
    repeat (98) @(posedge MCLK);
    reg_read(FRAME_REMAINING_OFFSET, v2);
    check(v2, v1 - 32'd10, "count per bit time");
    $display("t_timer done");
  endtask : t_timer

  // Controller reset returns the interval to nominal; software then writes its value back with the toggle bit flipped
  task automatic t_rst;
    reg_write(FRAME_INTERVAL_OFFSET, 32'h0123_0005);
    reg_read(FRAME_INTERVAL_OFFSET, v2);
    check(v2, 32'h0123_0005, "interval saved");
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    reg_read(FRAME_INTERVAL_OFFSET, v1);
    check(v1, FRAME_INTERVAL_RESET, "interval after reset");
    reg_read(DONE_HEAD_OFFSET, v1);
    check(v1, 32'h0000_0000, "head after reset");
    check({17'h00000, PACKET_BUDGET}, 32'h0000_0000, "budget after reset");
    // Restore must land before the first bit time after release loads the counter
    reg_write(FRAME_INTERVAL_OFFSET, v2 ^ 32'h8000_0000);
    $display("t_rst done");
  endtask : t_rst

  task automatic wait_sof(output int n);
    n = 0;
    do begin
      @(posedge MCLK);
      #1;
      n = n + 1;
    end while (SOF !== 1'b1 && n < 400);
  endtask : wait_sof

  // A frame lasts interval plus one bit times; a retune counts from the next frame
  task automatic t_frame;
    int n;
    wait_sof(n);
    check({31'h0, SOF}, 32'h0000_0001, "first frame start");
    wait_sof(n);
    check(n, 32'((5 + 1) * BIT_TIME_CYCLES), "frame length");
    @(posedge MCLK);
    #1;
    check({17'h00000, PACKET_BUDGET}, 32'h0000_0123, "budget load");
    reg_read(FRAME_REMAINING_OFFSET, v1);
    check(v1, 32'h8000_0005, "toggle copied");
    reg_write(FRAME_INTERVAL_OFFSET, 32'h0456_0007);
    wait_sof(n);
    wait_sof(n);
    check(n, 32'((7 + 1) * BIT_TIME_CYCLES), "retuned length");
    @(posedge MCLK);
    #1;
    check({17'h00000, PACKET_BUDGET}, 32'h0000_0456, "budget reload");
    reg_read(FRAME_REMAINING_OFFSET, v1);
    check(v1, 32'h0000_0007, "toggle copied back");
    $display("t_frame done");
  endtask : t_frame

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    t_reset();
    t_regs();
    t_done();
    t_post();
    t_timer();
    t_rst();
    t_frame();
    test_done();
  end
endmodule : tb_top
